// ==== logic/boe_pkg.sv ====
// shared constants and types for the bit operation execute unit
`default_nettype none
package boe_pkg;

   localparam int DATA_W    = 8;
   localparam int ADDR_W    = 8;
   localparam int FLAG_W    = 4;
   localparam int BIT_W     = 3;
   localparam int MEM_DEPTH = 16;
   localparam int MEM_IDX_W = 4;

   // register bus byte map
   localparam logic [ADDR_W-1:0] OFS_PORT = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_DIR  = 8'h01;
   localparam logic [ADDR_W-1:0] OFS_FLAG = 8'h02;
   localparam logic [ADDR_W-1:0] OFS_PIN  = 8'h03;
   localparam logic [ADDR_W-1:0] OFS_MEM  = 8'h10;
   localparam logic [ADDR_W-1:0] MEM_MASK = 8'hf0;

   // io space addresses seen by bit instructions
   localparam logic [MEM_IDX_W-1:0] IO_PORT = 4'h0;
   localparam logic [MEM_IDX_W-1:0] IO_DIR  = 4'h1;
   localparam logic [MEM_IDX_W-1:0] IO_FLAG = 4'h2;

   // flag bit positions
   localparam int FLAG_Z  = 0;
   localparam int FLAG_C  = 1;
   localparam int FLAG_AC = 2;
   localparam int FLAG_OV = 3;

   // reset values and the single-bit mask seed
   localparam logic [DATA_W-1:0] PORT_RST = 8'h00;
   localparam logic [DATA_W-1:0] DIR_RST  = 8'h00;
   localparam logic [FLAG_W-1:0] FLAG_RST = 4'h0;
   localparam logic [DATA_W-1:0] MEM_RST  = 8'h00;
   localparam logic [DATA_W-1:0] BIT_ONE  = 8'h01;
   localparam logic [DATA_W-1:0] RD_ZERO  = 8'h00;

   typedef enum logic [1:0]
   {
      op_nop        = 2'h0,
      bit_clear_op  = 2'h1,
      bit_set_op    = 2'h3,
      swap_carry_op = 2'h2
   } boe_op_type;

   typedef enum logic
   {
      space_io  = 1'b0,
      space_mem = 1'b1
   } boe_space_type;

   typedef struct packed
   {
      boe_op_type            op;
      boe_space_type         space;
      logic [MEM_IDX_W-1:0]  addr;
      logic [BIT_W-1:0]      bit_idx;
   } boe_instr_type;

   typedef struct packed
   {
      logic [ADDR_W-1:0]     addr;
      logic [DATA_W-1:0]     wdata;
      logic                  we;
      logic                  re;
   } boe_bus_type;

endpackage : boe_pkg
`default_nettype wire

// ==== logic/boe_bit_op_unit.sv ====
// bit clear and bit set execution with port and memory, carry exchange with the port only
//
// Local design decisions: the address map and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module boe_bit_op_unit
(
   input  wire  logic                          clk,
   input  wire  logic                          sys_rst,
   input  wire  boe_pkg::boe_bus_type          bus,
   output var   logic [boe_pkg::DATA_W-1:0]    rdata,
   input  wire  logic                          instr_valid,
   input  wire  boe_pkg::boe_instr_type        instr,
   output var   logic                          instr_done,
   input  wire  logic [boe_pkg::DATA_W-1:0]    port_pin_in,
   output var   logic [boe_pkg::DATA_W-1:0]    port_out,
   output var   logic [boe_pkg::DATA_W-1:0]    port_oe,
   output var   logic [boe_pkg::FLAG_W-1:0]    flags
);
   import boe_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // state

   logic [DATA_W-1:0]   port_q;
   logic [DATA_W-1:0]   port_d;
   logic [DATA_W-1:0]   dir_q;
   logic [DATA_W-1:0]   dir_d;
   logic [FLAG_W-1:0]   flag_q;
   logic [FLAG_W-1:0]   flag_d;
   logic [DATA_W-1:0]   mem_q [MEM_DEPTH];
   logic [DATA_W-1:0]   rdata_q;
   logic                done_q;

   ////////////////////////////////////////////////////////////////////////
   // instruction decode

   logic                is_io;
   logic                is_mem;
   logic                is_clr;
   logic                is_set;
   logic                is_bitop;
   logic                swap_hit;
   logic                swap_out;
   logic                swap_in;
   logic [DATA_W-1:0]   mask;
   logic [DATA_W-1:0]   io_cur;
   logic [DATA_W-1:0]   io_new;
   logic [DATA_W-1:0]   mem_cur;
   logic [DATA_W-1:0]   mem_new;
   logic                bus_mem_hit;
   logic                bus_port_we;
   logic                bus_dir_we;
   logic                bus_flag_we;
   logic                carry_bit;
   logic                pin_bit;

   assign is_io    = instr_valid && (instr.space == space_io);
   assign is_mem   = instr_valid && (instr.space == space_mem);
   assign is_clr   = (instr.op == bit_clear_op);
   assign is_set   = (instr.op == bit_set_op);
   assign is_bitop = is_clr || is_set;
   assign mask     = BIT_ONE << instr.bit_idx;

   // only the port address can exchange with carry: output bits take carry into the latch, input bits load the pin into carry
   assign swap_hit = is_io && (instr.op == swap_carry_op)
                     && (instr.addr == IO_PORT);
   assign swap_out = swap_hit && dir_q[instr.bit_idx];
   assign swap_in  = swap_hit && !dir_q[instr.bit_idx];

   always_comb
   begin
      case (instr.addr)
         IO_PORT: io_cur = port_q;
         IO_DIR:  io_cur = dir_q;
         IO_FLAG: io_cur = {{(DATA_W-FLAG_W){1'b0}}, flag_q};
         default: io_cur = RD_ZERO;
      endcase
   end

   // read-modify-write keeps every bit outside the mask
   always_comb
   begin
      if (is_set)
      begin
         io_new = io_cur | mask;
      end
      else
      begin
         io_new = io_cur & ~mask;
      end
   end

   assign mem_cur = mem_q[instr.addr];

   always_comb
   begin
      if (is_set)
      begin
         mem_new = mem_cur | mask;
      end
      else
      begin
         mem_new = mem_cur & ~mask;
      end
   end

   assign bus_mem_hit = ((bus.addr & MEM_MASK) == OFS_MEM);

   // the pin register is read only, so it gets no write strobe
   assign bus_port_we = bus.we && (bus.addr == OFS_PORT);
   assign bus_dir_we  = bus.we && (bus.addr == OFS_DIR);
   assign bus_flag_we = bus.we && (bus.addr == OFS_FLAG);

   // the two bits a swap can move, picked once for both directions
   assign carry_bit = flag_q[FLAG_C];
   assign pin_bit   = port_pin_in[instr.bit_idx];

   ////////////////////////////////////////////////////////////////////////
   // next values; the instruction wins over a bus write in the same cycle
   // since the sequencer owns the core's view of these registers

   always_comb
   begin
      port_d = port_q;
      if (bus_port_we)
      begin
         port_d = bus.wdata;
      end
      if (is_io && is_bitop && (instr.addr == IO_PORT))
      begin
         port_d = io_new;
      end
      if (swap_out)
      begin
         // start from the old latch so a same-cycle bus write cannot leak in
         port_d                = port_q;
         port_d[instr.bit_idx] = carry_bit;
      end
   end

   always_comb
   begin
      dir_d = dir_q;
      if (bus_dir_we)
      begin
         dir_d = bus.wdata;
      end
      if (is_io && is_bitop && (instr.addr == IO_DIR))
      begin
         dir_d = io_new;
      end
   end

   // bit ops on port or memory never touch flags unless they target them
   always_comb
   begin
      flag_d = flag_q;
      if (bus_flag_we)
      begin
         flag_d = bus.wdata[FLAG_W-1:0];
      end
      if (is_io && is_bitop && (instr.addr == IO_FLAG))
      begin
         flag_d = io_new[FLAG_W-1:0];
      end
      if (swap_in)
      begin
         flag_d         = flag_q;
         flag_d[FLAG_C] = pin_bit;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // registers

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         port_q <= PORT_RST;
      end
      else
      begin
         port_q <= port_d;
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         dir_q <= DIR_RST;
      end
      else
      begin
         dir_q <= dir_d;
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         flag_q <= FLAG_RST;
      end
      else
      begin
         flag_q <= flag_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // data memory, one flip-flop byte per entry

   for (genvar i = 0; i < MEM_DEPTH; i++)
   begin : g_mem
      localparam logic [MEM_IDX_W-1:0] IDX = MEM_IDX_W'(i);
      always_ff @(posedge clk)
      begin
         if (sys_rst)
         begin
            mem_q[i] <= MEM_RST;
         end
         else if (is_mem && is_bitop && (instr.addr == IDX))
         begin
            mem_q[i] <= mem_new;
         end
         else if (bus.we && bus_mem_hit
                  && (bus.addr[MEM_IDX_W-1:0] == IDX))
         begin
            mem_q[i] <= bus.wdata;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // completion pulse, one cycle after the instruction is taken

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         done_q <= 1'b0;
      end
      else
      begin
         done_q <= instr_valid;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // register read, data valid the cycle after the strobe only

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         rdata_q <= RD_ZERO;
      end
      else if (bus.re)
      begin
         if (bus_mem_hit)
         begin
            rdata_q <= mem_q[bus.addr[MEM_IDX_W-1:0]];
         end
         else
         begin
            case (bus.addr)
               OFS_PORT: rdata_q <= port_q;
               OFS_DIR:  rdata_q <= dir_q;
               OFS_FLAG: rdata_q <= {{(DATA_W-FLAG_W){1'b0}}, flag_q};
               OFS_PIN:  rdata_q <= port_pin_in;
               default:  rdata_q <= RD_ZERO;
            endcase
         end
      end
      else
      begin
         rdata_q <= RD_ZERO;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs; pins follow the direction register directly

   assign rdata      = rdata_q;
   assign instr_done = done_q;
   assign port_out   = port_q;
   assign port_oe    = dir_q;
   assign flags      = flag_q;

endmodule : boe_bit_op_unit
`default_nettype wire

// ==== tb/boe_bit_op_chk.sv ====
// port assertions for the bit operation unit
`timescale 1ns/100ps
`default_nettype none
module boe_bit_op_chk
(
   input wire logic                       clk,
   input wire logic                       sys_rst,
   input wire boe_pkg::boe_bus_type       bus,
   input wire logic [boe_pkg::DATA_W-1:0] rdata,
   input wire logic                       instr_valid,
   input wire boe_pkg::boe_instr_type     instr,
   input wire logic                       instr_done,
   input wire logic [boe_pkg::DATA_W-1:0] port_pin_in,
   input wire logic [boe_pkg::DATA_W-1:0] port_out,
   input wire logic [boe_pkg::DATA_W-1:0] port_oe,
   input wire logic [boe_pkg::FLAG_W-1:0] flags
);
   import boe_pkg::*;
   logic       io_port;
   logic       swp;
   logic [7:0] m;
   assign io_port = instr_valid && instr.space == space_io
                    && instr.addr == IO_PORT;
   assign swp = io_port && instr.op == swap_carry_op;
   assign m = 8'h01 << instr.bit_idx;
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   ////////////////////////////////////////////////////////////////////////////
   done_pulse_a: assert property (instr_done == $past(instr_valid))
      else $error("done pulse wrong");
   io_clear_a: assert property (
      io_port && instr.op == bit_clear_op |=> $stable(flags)
      && port_out == ($past(port_out) & ~$past(m)))
      else $error("port clear wrong");
   io_set_a: assert property (
      io_port && instr.op == bit_set_op |=> $stable(flags)
      && port_out == ($past(port_out) | $past(m)))
      else $error("port set wrong");
   swap_out_a: assert property (
      swp && port_oe[instr.bit_idx] |=> port_out ==
      (($past(port_out) & ~$past(m))
      | ({8{$past(flags[FLAG_C])}} & $past(m))))
      else $error("carry not sent to port");
   swap_in_a: assert property (
      swp && !port_oe[instr.bit_idx] |=> $stable(port_out)
      && flags[FLAG_C] == $past(port_pin_in[instr.bit_idx]))
      else $error("pin not loaded to carry");
   swap_flags_a: assert property (
      swp |=> (flags & 4'hd) == ($past(flags) & 4'hd))
      else $error("swap touched other flags");
   dir_write_a: assert property (
      bus.we && bus.addr == OFS_DIR && !instr_valid
      |=> port_oe == $past(bus.wdata))
      else $error("direction write lost");
   dir_read_a: assert property (
      bus.re && bus.addr == OFS_DIR |=> rdata == $past(port_oe))
      else $error("direction read wrong");
   mem_flags_a: assert property (
      instr_valid && instr.space == space_mem && !bus.we
      |=> $stable(flags) && $stable(port_out))
      else $error("memory op touched flags or port");
   rdata_idle_a: assert property (!bus.re |=> rdata == 8'h00)
      else $error("read data held too long");
endmodule : boe_bit_op_chk
bind boe_bit_op_unit boe_bit_op_chk u_chk
(
   .clk(clk), .sys_rst(sys_rst), .bus(bus), .rdata(rdata),
   .instr_valid(instr_valid), .instr(instr), .instr_done(instr_done),
   .port_pin_in(port_pin_in), .port_out(port_out), .port_oe(port_oe),
   .flags(flags)
);
`default_nettype wire

// ==== tb/boe_pin_model.sv ====
// pin model: driven pins read back, input pins follow an outside level
`timescale 1ns/100ps
`default_nettype none
module boe_pin_model
(
   input  wire logic [7:0] port_out,
   input  wire logic [7:0] port_oe,
   input  wire logic [7:0] ext_level,
   output var  logic [7:0] port_pin_in
);
   assign port_pin_in = (port_out & port_oe) | (ext_level & ~port_oe);
endmodule : boe_pin_model
`default_nettype wire

// ==== tb/bit_op_execute_unit_tb.sv ====
// testbench for the bit operation unit
`timescale 1ns/100ps
`default_nettype none
module bit_op_execute_unit_tb;
   import boe_pkg::*;
   logic          clk = 1'b0;
   logic          sys_rst = 1'b1;
   boe_bus_type   bus = '0;
   logic          instr_valid = 1'b0;
   boe_instr_type instr = '0;
   logic [7:0]    ext = 8'h00;
   wire logic [7:0] rdata, pin, pout, poe;
   wire logic [3:0] flags;
   wire logic       done;
   int failures = 0;
   int checks_done = 0;
   always #4 clk = ~clk;
   boe_bit_op_unit dut (.clk(clk), .sys_rst(sys_rst), .bus(bus),
      .rdata(rdata), .instr_valid(instr_valid), .instr(instr),
      .instr_done(done), .port_pin_in(pin), .port_out(pout),
      .port_oe(poe), .flags(flags));
   boe_pin_model pins (.port_out(pout), .port_oe(poe),
      .ext_level(ext), .port_pin_in(pin));
   ////////////////////////////////////////////////////////////////////////////
   task chk(input logic [7:0] s, input logic [7:0] e);
      checks_done++;
      if (s !== e)
      begin
         failures++;
         $display("CHECK FAILED %0t got %h want %h", $time, s, e);
      end
   endtask : chk
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk) bus <= '{a, d, 1'b1, 1'b0};
      @(posedge clk) bus <= '0;
   endtask : wr
   // data stands only in the cycle after the strobe, so look there
   task rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk) bus <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clk) bus <= '0;
      #1 chk(rdata, e);
   endtask : rd
   task ex(input boe_op_type o, input boe_space_type s,
           input logic [3:0] a, input logic [2:0] b);
      @(posedge clk)
      begin
         instr_valid <= 1'b1;
         instr <= '{o, s, a, b};
      end
      @(posedge clk) instr_valid <= 1'b0;
      #1 chk({7'h00, done}, 8'h01);
   endtask : ex
   task complete_run;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : complete_run
   initial
   begin
      #40000;
      failures++;
      complete_run();
   end
   initial
   begin
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      rd(OFS_PORT, 8'h00);
      rd(OFS_DIR, 8'h00);
      rd(OFS_FLAG, 8'h00);
      rd(8'h15, 8'h00);
      wr(OFS_PORT, 8'ha5);
      wr(OFS_FLAG, 8'h0d);
      ex(bit_set_op, space_io, IO_PORT, 3'h6);
      chk(pout, 8'he5);
      chk({4'h0, flags}, 8'h0d);
      ex(bit_clear_op, space_io, IO_PORT, 3'h0);
      chk(pout, 8'he4);
      chk({4'h0, flags}, 8'h0d);
      wr(8'h15, 8'h0f);
      ex(bit_set_op, space_mem, 4'h5, 3'h7);
      rd(8'h15, 8'h8f);
      ex(bit_clear_op, space_mem, 4'h5, 3'h0);
      rd(8'h15, 8'h8e);
      chk({4'h0, flags}, 8'h0d);
      wr(OFS_DIR, 8'h01);
      #1 chk(poe, 8'h01);
      ex(bit_set_op, space_io, IO_FLAG, 3'h1);
      ex(swap_carry_op, space_io, IO_PORT, 3'h0);
      chk(pout, 8'he5);
      chk({4'h0, flags}, 8'h0f);
      ex(bit_clear_op, space_io, IO_FLAG, 3'h1);
      ex(swap_carry_op, space_io, IO_PORT, 3'h0);
      chk(pout, 8'he4);
      wr(OFS_DIR, 8'h00);
      #1 chk(poe, 8'h00);
      @(posedge clk) ext <= 8'h01;
      ex(swap_carry_op, space_io, IO_PORT, 3'h0);
      chk({4'h0, flags}, 8'h0f);
      chk(pout, 8'he4);
      rd(OFS_PIN, 8'h01);
      @(posedge clk) ext <= 8'h00;
      ex(swap_carry_op, space_io, IO_PORT, 3'h0);
      chk({4'h0, flags}, 8'h0d);
      rd(8'h08, 8'h00);
      wr(OFS_PIN, 8'hff);
      rd(OFS_PIN, 8'h00);
      @(posedge clk) #1 chk(rdata, 8'h00);
      ex(bit_set_op, space_io, IO_DIR, 3'h3);
      chk(poe, 8'h08);
      ex(bit_clear_op, space_io, IO_DIR, 3'h3);
      chk(poe, 8'h00);
      ex(op_nop, space_io, IO_PORT, 3'h2);
      chk(pout, 8'he4);
      @(posedge clk) #1 chk({7'h00, done}, 8'h00);
      ex(swap_carry_op, space_mem, 4'h5, 3'h1);
      rd(8'h15, 8'h8e);
      chk({4'h0, flags}, 8'h0d);
      @(posedge clk) sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      #1 chk(pout, 8'h00);
      chk(poe, 8'h00);
      chk({4'h0, flags}, 8'h00);
      rd(8'h15, 8'h00);
      complete_run();
   end
endmodule : bit_op_execute_unit_tb
`default_nettype wire
